/* core/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Pins in, synchronised levels out.
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_reset_value,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
        end else begin
          meta_q[gi] <= i_async[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // The reset value input is unused for flops; kept idle-high to match chip select idle.
  assign o_sync = sync_q & (i_reset_value | ~i_reset_value);

endmodule : pin_sync
`default_nettype wire

/* core/serial_port_pkg.sv */
// Constants shared by the serial configuration port and its pin synchroniser.
// Assumes a single 100 MHz system clock; all link pins are asynchronous to it.
package serial_port_pkg;

  localparam int ADDR_W = 15;
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int RW_BIT = 15;
  localparam int REG_COUNT = 32;

  localparam logic [14:0] REG_CONFIG = 15'h0000;
  localparam int CFG_LSB_FIRST_A = 6;
  localparam int CFG_LSB_FIRST_B = 1;
  localparam int CFG_ADDR_STEP_A = 5;
  localparam int CFG_ADDR_STEP_B = 2;
  localparam int CFG_SDO_ACTIVE_A = 4;
  localparam int CFG_SDO_ACTIVE_B = 3;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  localparam logic [14:0] REG_TUNING_BASE = 15'h0010;
  localparam int TUNING_BYTES = 6;
  localparam logic [14:0] REG_PHASE_BASE = 15'h0016;
  localparam int PHASE_BYTES = 2;
  localparam logic [14:0] REG_LOAD_REQUEST = 15'h0018;
  localparam int LOAD_REQUEST_BIT = 0;

  localparam int SYNC_WIDTH = 3;

endpackage : serial_port_pkg

/* core/serial_register_port.sv */
// Serial configuration port: instruction phase, byte data phase, register file.
// Assumes the serial clock, chip select and data pin come from an outside master
// and are oversampled by the 100 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module serial_register_port
  import serial_port_pkg::*;
(
  // System clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Serial pins from the controller.
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdio_in,
  // Shared data pin drive.
  output logic o_sdio_out,
  output logic o_sdio_oe,
  // Separate output pin drive.
  output logic o_serial_output_pin,
  output logic o_serial_output_pin_oe,
  // Applied oscillator settings and configuration byte.
  output logic [TUNING_BYTES*8-1:0] o_oscillator_tuning_word,
  output logic [PHASE_BYTES*8-1:0] o_phase_offset,
  output logic [7:0] o_config
);
  import serial_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic sclk_prev;
    logic [3:0] bit_cnt;
    logic data_phase;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [INSTR_BITS-1:0] instr;
    logic [BYTE_BITS-1:0] rx_byte;
    logic [BYTE_BITS-1:0] tx_byte;
    logic out_bit;
    logic sdio_oe;
    logic sdo_oe;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [TUNING_BYTES*8-1:0] tuning;
    logic [PHASE_BYTES*8-1:0] phase;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [SYNC_WIDTH-1:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdio_s;

  pin_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_async({i_sclk, i_cs_n, i_sdio_in}),
    .i_reset_value({SYNC_WIDTH{1'b1}}),
    .o_sync(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sdio_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register access helpers.

  function automatic logic [7:0] read_reg(input logic [REG_COUNT-1:0][7:0] regs,
                                          input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a < 15'(REG_COUNT)) begin
      v = regs[a[4:0]];
    end
    return v;
  endfunction : read_reg

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic rise;
    logic fall;
    logic lsb_first;
    logic step_up;
    logic four_wire;
    logic [INSTR_BITS-1:0] instr_n;
    logic [BYTE_BITS-1:0] rx_n;
    logic [ADDR_W-1:0] next_addr;
    logic [2:0] idx;
    rise = 1'b0;
    fall = 1'b0;
    lsb_first = 1'b0;
    step_up = 1'b0;
    four_wire = 1'b0;
    instr_n = '0;
    rx_n = '0;
    next_addr = '0;
    idx = '0;
    s_d = s_q;

    rise = sclk_s & ~s_q.sclk_prev;
    fall = ~sclk_s & s_q.sclk_prev;
    lsb_first = s_q.regs[0][CFG_LSB_FIRST_A] | s_q.regs[0][CFG_LSB_FIRST_B];
    step_up = s_q.regs[0][CFG_ADDR_STEP_A] | s_q.regs[0][CFG_ADDR_STEP_B];
    four_wire = s_q.regs[0][CFG_SDO_ACTIVE_A] | s_q.regs[0][CFG_SDO_ACTIVE_B];
    s_d.sclk_prev = sclk_s;

    if (cs_n_s) begin
      // Idle: restart sequencing and release both output pins.
      s_d.bit_cnt = '0;
      s_d.data_phase = 1'b0;
      s_d.sdio_oe = 1'b0;
      s_d.sdo_oe = 1'b0;
    end else begin
      if (rise && !s_q.data_phase) begin
        // Both orders leave R/W in bit 15 and A0 in bit 0.
        if (lsb_first) begin
          instr_n = {sdio_s, s_q.instr[INSTR_BITS-1:1]};
        end else begin
          instr_n = {s_q.instr[INSTR_BITS-2:0], sdio_s};
        end
        s_d.instr = instr_n;
        if (s_q.bit_cnt == 4'(INSTR_BITS - 1)) begin
          s_d.data_phase = 1'b1;
          s_d.bit_cnt = '0;
          s_d.rw = instr_n[RW_BIT];
          s_d.addr = instr_n[ADDR_W-1:0];
          s_d.tx_byte = read_reg(s_q.regs, instr_n[ADDR_W-1:0]);
        end else begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
      end else if (rise) begin
        if (lsb_first) begin
          rx_n = {sdio_s, s_q.rx_byte[BYTE_BITS-1:1]};
        end else begin
          rx_n = {s_q.rx_byte[BYTE_BITS-2:0], sdio_s};
        end
        s_d.rx_byte = rx_n;
        if (s_q.bit_cnt == 4'(BYTE_BITS - 1)) begin
          s_d.bit_cnt = '0;
          if (!s_q.rw && s_q.addr < 15'(REG_COUNT)) begin
            s_d.regs[s_q.addr[4:0]] = rx_n;
            if (s_q.addr == REG_LOAD_REQUEST && rx_n[LOAD_REQUEST_BIT]) begin
              // Pending bytes move to the oscillator together; request self-clears.
              for (int i = 0; i < TUNING_BYTES; i++) begin
                s_d.tuning[8*i +: 8] = s_q.regs[REG_TUNING_BASE[4:0] + 5'(i)];
              end
              for (int i = 0; i < PHASE_BYTES; i++) begin
                s_d.phase[8*i +: 8] = s_q.regs[REG_PHASE_BASE[4:0] + 5'(i)];
              end
              s_d.regs[REG_LOAD_REQUEST[4:0]][LOAD_REQUEST_BIT] = 1'b0;
            end
          end
          if (step_up) begin
            next_addr = s_q.addr + 15'h0001;
          end else begin
            next_addr = s_q.addr - 15'h0001;
          end
          s_d.addr = next_addr;
          s_d.tx_byte = read_reg(s_d.regs, next_addr);
        end else begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
      end

      if (fall && s_q.data_phase && s_q.rw) begin
        idx = lsb_first ? s_q.bit_cnt[2:0] : 3'h7 - s_q.bit_cnt[2:0];
        s_d.out_bit = s_q.tx_byte[idx];
      end
      s_d.sdio_oe = s_q.data_phase & s_q.rw & ~four_wire;
      s_d.sdo_oe = s_q.data_phase & s_q.rw & four_wire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.sclk_prev <= 1'b1;
      s_q.regs[0] <= CONFIG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sdio_out = s_q.out_bit;
  assign o_sdio_oe = s_q.sdio_oe;
  assign o_serial_output_pin = s_q.out_bit;
  assign o_serial_output_pin_oe = s_q.sdo_oe;
  assign o_oscillator_tuning_word = s_q.tuning;
  assign o_phase_offset = s_q.phase;
  assign o_config = s_q.regs[0];

endmodule : serial_register_port
`default_nettype wire

/* sim/serial_register_port_props.sv */
// Pin-level checker for the serial register port.
// Assumes it is bound to the port's top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module serial_register_port_props
  import serial_port_pkg::*;
(
  // Clock, reset and serial pins.
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdio_in,
  // Driven outputs.
  input wire logic o_sdio_out,
  input wire logic o_sdio_oe,
  input wire logic o_serial_output_pin,
  input wire logic o_serial_output_pin_oe,
  input wire logic [TUNING_BYTES*8-1:0] o_oscillator_tuning_word,
  input wire logic [PHASE_BYTES*8-1:0] o_phase_offset,
  input wire logic [7:0] o_config
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence cs_idle;
    i_cs_n [*8];
  endsequence
  sequence clk_high;
    (!i_cs_n && i_sclk) [*6];
  endsequence
  one_driver_a: assert property (!(o_sdio_oe && o_serial_output_pin_oe))
    else $error("both data pins driven");
  same_bit_a: assert property (o_sdio_out == o_serial_output_pin)
    else $error("data pins disagree");
  pin_release_a: assert property (cs_idle |-> !o_sdio_oe && !o_serial_output_pin_oe)
    else $error("pin driven while deselected");
  shared_mode_a: assert property (o_sdio_oe |-> !(o_config[4] || o_config[3]))
    else $error("shared pin driven in four-wire form");
  four_wire_a: assert property (o_serial_output_pin_oe |-> (o_config[4] || o_config[3]))
    else $error("output pin driven in three-wire form");
  read_start_a: assert property ($rose(o_sdio_oe || o_serial_output_pin_oe) |->
    $past(i_cs_n, 3) == 1'b0) else $error("read drive without selection");
  bit_hold_a: assert property (clk_high |-> $stable(o_sdio_out))
    else $error("read bit moved while clock high");
  tuning_hold_a: assert property (cs_idle |=> $stable(o_oscillator_tuning_word) &&
    $stable(o_phase_offset)) else $error("tuning outputs moved while idle");
  config_hold_a: assert property (cs_idle |=> $stable(o_config))
    else $error("config moved while idle");
endmodule : serial_register_port_props
bind serial_register_port serial_register_port_props u_props (.i_clock, .i_resetn, .i_sclk,
  .i_cs_n, .i_sdio_in, .o_sdio_out, .o_sdio_oe, .o_serial_output_pin, .o_serial_output_pin_oe,
  .o_oscillator_tuning_word, .o_phase_offset, .o_config);
`default_nettype wire

/* sim/serial_register_port_test.sv */
// Self-checking bench for the serial register port against a byte-level model.
// Assumes the controller model drives every serial pin at falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module serial_register_port_test;
  import serial_port_pkg::*;
  logic clk = 1'b0, rstn = 1'b0;
  logic sclk, cs_n, mosi, so, so_oe, sd, sd_oe;
  logic [47:0] tw;
  logic [15:0] ph;
  logic [7:0] cfg;
  wire logic sdio_w = sd_oe ? sd : mosi;
  wire logic sdo_w = so_oe ? so : ~mosi;
  int mismatches = 0, num_checks = 0, cyc = 0;
  logic [31:0] seed = 32'h2339, r;
  logic [7:0] mem [32] = '{default: 8'h00};
  logic [63:0] ap = '0;
  serial_register_port u_serial_register_port (.i_clock(clk), .i_resetn(rstn), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_sdio_in(sdio_w), .o_sdio_out(sd), .o_sdio_oe(sd_oe),
    .o_serial_output_pin(so), .o_serial_output_pin_oe(so_oe),
    .o_oscillator_tuning_word(tw), .o_phase_offset(ph), .o_config(cfg));
  spi_master_model u_spi_master_model (.i_clock(clk), .i_sdio(sdio_w), .i_sdo(sdo_w),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // Runs one frame on the pins, then replays it on the byte model and compares.
  task automatic run(input logic rw, input logic [14:0] a, input int tot, input logic [63:0] wd);
    logic [63:0] rd;
    u_spi_master_model.xfer(mem[0][6] | mem[0][1], mem[0][4] | mem[0][3], {rw, a}, tot, wd, rd);
    for (int k = 0; k < (tot - 16) / 8; k++) begin
      if (rw) chk(rd[8*k+:8], a < 15'd32 ? mem[a[4:0]] : 8'h00);
      else if (a < 15'd32) begin
        mem[a[4:0]] = (a == 15'd24) ? wd[8*k+:8] & 8'hfe : wd[8*k+:8];
        if (a == 15'd24 && wd[8*k]) for (int i = 0; i < 8; i++) ap[8*i+:8] = mem[16+i];
      end
      a = (mem[0][5] | mem[0][2]) ? a + 15'd1 : a - 15'd1;
    end
    chk({ph, tw}, ap);
    chk(cfg, mem[0]);
    $display("transfer of %0d bits done at %0t", tot, $time);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk({ph, tw, cfg[7:0]} >> 8, 64'h0);
    run(1'b0, 15'h0017, 40, {xs(), xs()});
    run(1'b1, 15'h0017, 40, '0);
    run(1'b0, 15'h0018, 24, 64'h01);
    run(1'b0, 15'h0000, 24, 64'h24);
    run(1'b0, 15'h001e, 48, {xs(), xs()});
    run(1'b1, 15'h001e, 48, '0);
    run(1'b0, 15'h0000, 24, 64'h7e);
    run(1'b0, 15'h0005, 10, {xs(), xs()});
    run(1'b0, 15'h0005, 28, {xs(), xs()});
    for (int i = 0; i < 8; i++) begin
      r = xs();
      run(r[0], {11'h000, r[4:1] | 4'h1}, 32, {xs(), xs()});
    end
    run(1'b1, 15'h0017, 40, '0);
    run(1'b0, 15'h0018, 24, 64'h01);
    wrap_up();
  end
endmodule : serial_register_port_test
`default_nettype wire

/* sim/spi_master_model.sv */
// Behavioural serial controller driving the port's pins one bit at a time.
// Assumes the bench resolves the shared pin and calls xfer between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  // Clock and returned pin levels.
  input wire logic i_clock,
  input wire logic i_sdio,
  input wire logic i_sdo,
  // Pins to the port.
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic xfer(input logic lsb, input logic four, input logic [15:0] ins,
                      input int tot, input logic [63:0] wd, output logic [63:0] rd);
    int idx;
    rd = '0;
    @(negedge i_clock) o_cs_n <= 1'b0;
    for (int p = 0; p < tot; p++) begin
      idx = 8 * ((p - 16) / 8) + (lsb ? (p - 16) % 8 : 7 - (p - 16) % 8);
      repeat (8) @(negedge i_clock);
      o_sclk <= 1'b0;
      if (p < 16) o_mosi <= ins[lsb ? p : 15 - p];
      else if (ins[15] && !four) o_mosi <= ~o_mosi;
      else o_mosi <= wd[idx];
      repeat (8) @(negedge i_clock);
      o_sclk <= 1'b1;
      if (p >= 16) rd[idx] = four ? i_sdo : i_sdio;
    end
    repeat (8) @(negedge i_clock);
    o_sclk <= 1'b0;
    repeat (8) @(negedge i_clock);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (16) @(negedge i_clock);
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire
